// file: rtl/bfmpc_pkg.sv
// Purpose: shared constants and types for the two-port queue port control
// Assumes: 36-bit data words, 64-deep queues, one system clock
// Notes: flag vectors are ordered {empty_n, almost_empty_n, almost_full_n, full_n}
package bfmpc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 36;              // data word width
  localparam int PTR_W = 6;                // queue pointer width
  localparam int CNT_W = 7;                // occupancy counter width
  localparam logic [CNT_W-1:0] QUEUE_DEPTH = 7'h40; // words per queue
  localparam int BYTE_W = 9;               // byte lane incl. parity bit
  localparam int HALF_W = 18;              // half word lane

  // ----------------------------------------------------------------
  // offset presets, selected by the strap pair at reset
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] OFFSET_SEL0 = 7'h04; // strap 00
  localparam logic [CNT_W-1:0] OFFSET_SEL1 = 7'h08; // strap 01
  localparam logic [CNT_W-1:0] OFFSET_SEL2 = 7'h0c; // strap 10
  localparam logic [CNT_W-1:0] OFFSET_SEL3 = 7'h10; // strap 11
  localparam logic [CNT_W-1:0] OFFSET_RESET = 7'h04; // value before strap load
  localparam logic [1:0] STRAP_WAIT = 2'h3;  // cycles before the strap is taken

  // ----------------------------------------------------------------
  // reset values of flags
  // ----------------------------------------------------------------
  localparam logic [3:0] FLAGS_RESET = 4'h3; // empty, almost empty asserted
  localparam int F_EMPTY = 3;              // flag vector positions
  localparam int F_AEMPTY = 2;
  localparam int F_AFULL = 1;
  localparam int F_FULL = 0;

  // ----------------------------------------------------------------
  // port B transfer widths, coded from {width_sel1, width_sel0}
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BW_LONG = 2'b00,
    BW_WORD = 2'b01,
    BW_BYTE = 2'b10,
    BW_MAIL = 2'b11
  } bfmpc_width_t;

  // ----------------------------------------------------------------
  // port control bundles
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic selectN;   // chip select, active low
    logic dir;       // high write, low read
    logic enable;    // transfer enable
    logic mbSel;     // mailbox select
  } bfmpc_porta_t;

  typedef struct packed
  {
    logic selectN;   // chip select, active low
    logic dir;       // high write, low read
    logic enable;    // transfer enable
    logic [1:0] size; // {width_sel1, width_sel0}
    logic endianN;   // low selects big-endian
  } bfmpc_portb_t;

endpackage

// file: rtl/bfmpc_top.sv
// Purpose: port control for two opposite 64-word queues plus two mailboxes
// Assumes: port clocks and all pins are slow against ref_clk and sampled
// Notes: port clocks become one-cycle enables after a two flip-flop sync
`timescale 1ns/1ps

// Overview of operation
// - port A decodes queue/mailbox writes and reads
// - port B decodes queue/mailbox writes and reads
// - occupancy maps onto four flags per queue
// - almost full at sixty-four minus offset
// - almost full releases on second writer edge
// - late updates wait for the following edge
// - offset loads one of four presets
// - one 36-bit mailbox per direction
// - port A write captures forward mailbox
// - port B write captures reverse mailbox
// - mailbox write lowers flag, blocks rewrites
// - port A drives queue or mailbox data
// - port B drives queue or mailbox data
// - port B mailbox read raises its flag
// - port A mailbox read raises its flag
// - mailbox contents change only on write
// - port B long, half, byte widths, endian
// - width selection registered, applied next edge
// - queues hold whole words; mailboxes unsized
// - narrow reads deliver remainder from auxiliary
// - width change fetches fresh word, drops rest
// - unused narrow lanes carry arbitrary values
// - flags pass two stages in reader/writer clock
// - writes ignored while full flag low
// - reads ignored while empty flag low
module bfmpc_top
  import bfmpc_pkg::*;
(
  // system
  input wire logic ref_clk,
  input wire logic reset_n,
  // port A pins
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_dir,
  input wire logic port_a_enable,
  input wire logic port_a_mailbox_sel,
  input wire logic [DATA_W-1:0] portADataIn,
  output logic [DATA_W-1:0] portADataOut,
  output logic portADataOe,
  // port B pins
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_dir,
  input wire logic port_b_enable,
  input wire logic port_b_width_sel0,
  input wire logic port_b_width_sel1,
  input wire logic port_b_endian_sel,
  input wire logic [DATA_W-1:0] portBDataIn,
  output logic [DATA_W-1:0] portBDataOut,
  output logic portBDataOe,
  // offset strap
  input wire logic [1:0] offsetSel,
  // flags
  output logic port_a_empty_n,
  output logic port_a_almost_empty_n,
  output logic port_a_almost_full_n,
  output logic port_a_full_n,
  output logic port_b_empty_n,
  output logic port_b_almost_empty_n,
  output logic port_b_almost_full_n,
  output logic port_b_full_n,
  output logic a_to_b_mail_flag_n,
  output logic b_to_a_mail_flag_n
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // occupancy to {empty_n, almost_empty_n, almost_full_n, full_n}
  function automatic logic [3:0] occFlags(input logic [CNT_W-1:0] cnt,
                                          input logic [CNT_W-1:0] x);
    occFlags = {cnt != '0, cnt > x, cnt < (QUEUE_DEPTH - x), cnt != QUEUE_DEPTH};
  endfunction

  // a port acts when selected and enabled
  function automatic logic portGo(input logic selN, input logic en);
    portGo = ~selN & en;
  endfunction

  // move the next narrow portion into place for output
  function automatic logic [DATA_W-1:0] nextPortion(input logic [DATA_W-1:0] w,
                                                    input bfmpc_width_t bw,
                                                    input logic big);
    if (bw == BW_BYTE)
      nextPortion = big ? (w << BYTE_W) : (w >> BYTE_W);
    else
      nextPortion = big ? (w << HALF_W) : (w >> HALF_W);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 2 + 4 + 6 + 2 * DATA_W + 2;
  logic [SYNC_W-1:0] pinsRaw; // all pins gathered
  logic [SYNC_W-1:0] sync1_reg; // first stage, read only by second
  logic [SYNC_W-1:0] sync2_reg; // second stage, safe to use
  logic clkADly_reg; // delayed port A clock for edge find
  logic clkBDly_reg; // delayed port B clock for edge find

  assign pinsRaw = {port_a_clock, port_b_clock,
                    port_a_select_n, port_a_dir, port_a_enable, port_a_mailbox_sel,
                    port_b_select_n, port_b_dir, port_b_enable,
                    port_b_width_sel1, port_b_width_sel0, port_b_endian_sel,
                    portADataIn, portBDataIn, offsetSel};

  // two flip-flops on every pin
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      clkADly_reg <= 1'b0;
      clkBDly_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= pinsRaw;
      sync2_reg <= sync1_reg;
      clkADly_reg <= sync2_reg[SYNC_W-1];
      clkBDly_reg <= sync2_reg[SYNC_W-2];
    end
  end

  // unpack the synchronised pins
  bfmpc_porta_t ctlA; // port A controls
  bfmpc_portb_t ctlB; // port B controls
  logic [DATA_W-1:0] dinA; // port A data in
  logic [DATA_W-1:0] dinB; // port B data in
  logic [1:0] strapSync; // offset strap
  logic edgeA; // one-cycle enable at port A rising edge
  logic edgeB; // one-cycle enable at port B rising edge

  assign ctlA = bfmpc_porta_t'(sync2_reg[SYNC_W-3 -: 4]);
  assign ctlB = bfmpc_portb_t'(sync2_reg[SYNC_W-7 -: 6]);
  assign dinA = sync2_reg[2*DATA_W+1 -: DATA_W];
  assign dinB = sync2_reg[DATA_W+1 -: DATA_W];
  assign strapSync = sync2_reg[1:0];
  assign edgeA = sync2_reg[SYNC_W-1] & ~clkADly_reg;
  assign edgeB = sync2_reg[SYNC_W-2] & ~clkBDly_reg;

  // ----------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------
  logic goA; // port A cycle selected
  logic goB; // port B cycle selected
  logic bMail; // port B both size selects high
  logic aFifoWr, aMailWr, aFifoRd, aMailRd; // port A functions
  logic bFifoWr, bMailWr, bFifoRd, bMailRd; // port B functions

  assign goA = edgeA & portGo(ctlA.selectN, ctlA.enable);
  assign goB = edgeB & portGo(ctlB.selectN, ctlB.enable);
  assign bMail = (ctlB.size == BW_MAIL);
  assign aFifoWr = goA & ctlA.dir & ~ctlA.mbSel;
  assign aMailWr = goA & ctlA.dir & ctlA.mbSel;
  assign aFifoRd = goA & ~ctlA.dir & ~ctlA.mbSel;
  assign aMailRd = goA & ~ctlA.dir & ctlA.mbSel;
  assign bFifoWr = goB & ctlB.dir & ~bMail;
  assign bMailWr = goB & ctlB.dir & bMail;
  assign bFifoRd = goB & ~ctlB.dir & ~bMail;
  assign bMailRd = goB & ~ctlB.dir & bMail;

  // ----------------------------------------------------------------
  // offset preset
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] offset_reg; // threshold offset
  logic [1:0] strapCnt_reg; // wait for synchronised strap

  // strap is taken once, shortly after reset release
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      offset_reg <= OFFSET_RESET;
      strapCnt_reg <= '0;
    end
    else if (strapCnt_reg != STRAP_WAIT)
    begin
      strapCnt_reg <= strapCnt_reg + 2'h1;
      if (strapCnt_reg + 2'h1 == STRAP_WAIT)
      begin
        case (strapSync)
          2'b00: offset_reg <= OFFSET_SEL0;
          2'b01: offset_reg <= OFFSET_SEL1;
          2'b10: offset_reg <= OFFSET_SEL2;
          default: offset_reg <= OFFSET_SEL3;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // queue storage and occupancy
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] fwdMem [0:63]; // forward queue words
  logic [DATA_W-1:0] revMem [0:63]; // reverse queue words
  logic [PTR_W-1:0] fwdWrPtr_reg, fwdRdPtr_reg, revWrPtr_reg, revRdPtr_reg;
  logic [CNT_W-1:0] fwdCnt_reg, revCnt_reg; // words held
  logic fwdWrOk, fwdRdFetch, revWrOk, revRdOk; // accepted transfers
  logic [3:0] fwdRaw, revRaw; // flags straight from occupancy

  assign fwdRaw = occFlags(fwdCnt_reg, offset_reg);
  assign revRaw = occFlags(revCnt_reg, offset_reg);

  // memories hold whole words only
  always_ff @(posedge ref_clk)
  begin
    if (fwdWrOk)
      fwdMem[fwdWrPtr_reg] <= dinA;
    if (revWrOk)
      revMem[revWrPtr_reg] <= dinB;
  end

  // pointers and occupancy counts
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fwdWrPtr_reg <= '0;
      fwdRdPtr_reg <= '0;
      revWrPtr_reg <= '0;
      revRdPtr_reg <= '0;
      fwdCnt_reg <= '0;
      revCnt_reg <= '0;
    end
    else
    begin
      fwdWrPtr_reg <= fwdWrPtr_reg + PTR_W'(fwdWrOk);
      fwdRdPtr_reg <= fwdRdPtr_reg + PTR_W'(fwdRdFetch);
      revWrPtr_reg <= revWrPtr_reg + PTR_W'(revWrOk);
      revRdPtr_reg <= revRdPtr_reg + PTR_W'(revRdOk);
      fwdCnt_reg <= fwdCnt_reg + CNT_W'(fwdWrOk) - CNT_W'(fwdRdFetch);
      revCnt_reg <= revCnt_reg + CNT_W'(revWrOk) - CNT_W'(revRdOk);
    end
  end

  // ----------------------------------------------------------------
  // flag synchronisation, two stages per port clock
  // ----------------------------------------------------------------
  logic [1:0] auxLeft_reg; // narrow portions still in auxiliary
  logic [3:0] rawA, rawB; // unsynchronised flags per port
  logic [3:0] stgA_reg, stgB_reg; // first flag stage
  logic [3:0] flagA_reg, flagB_reg; // flags at the pins
  logic [3:0] nextA, nextB; // flag values taken at this edge

  // port A reads reverse, writes forward; port B the other way round
  assign rawA = {revRaw[3:2], fwdRaw[1:0]};
  assign rawB = {fwdRaw[3] | (auxLeft_reg != 2'h0), fwdRaw[2], revRaw[1:0]};
  // assertion is seen at once, release only after the second edge
  assign nextA = rawA & stgA_reg;
  assign nextB = rawB & stgB_reg;

  // raw level sampled at the edge; a change landing too late waits
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stgA_reg <= FLAGS_RESET;
      flagA_reg <= FLAGS_RESET;
    end
    else if (edgeA)
    begin
      stgA_reg <= rawA;
      flagA_reg <= nextA;
    end
  end

  // same two stages on the port B clock
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stgB_reg <= FLAGS_RESET;
      flagB_reg <= FLAGS_RESET;
    end
    else if (edgeB)
    begin
      stgB_reg <= rawB;
      flagB_reg <= nextB;
    end
  end

  assign {port_a_empty_n, port_a_almost_empty_n, port_a_almost_full_n, port_a_full_n} =
    flagA_reg;
  assign {port_b_empty_n, port_b_almost_empty_n, port_b_almost_full_n, port_b_full_n} =
    flagB_reg;

  // gate against the flag as it stands after this edge
  assign fwdWrOk = aFifoWr & nextA[F_FULL];
  assign revWrOk = bFifoWr & nextB[F_FULL];
  assign revRdOk = aFifoRd & nextA[F_EMPTY];

  // ----------------------------------------------------------------
  // mailboxes
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mailAB_reg, mailBA_reg; // bypass words
  logic mailABFlagN_reg, mailBAFlagN_reg; // high when free

  // contents move only on an accepted write
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mailAB_reg <= '0;
      mailBA_reg <= '0;
    end
    else
    begin
      if (aMailWr & mailABFlagN_reg)
        mailAB_reg <= dinA;
      if (bMailWr & mailBAFlagN_reg)
        mailBA_reg <= dinB;
    end
  end

  // a write wins over a read in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mailABFlagN_reg <= 1'b1;
      mailBAFlagN_reg <= 1'b1;
    end
    else
    begin
      if (aMailWr & mailABFlagN_reg)
        mailABFlagN_reg <= 1'b0;
      else if (bMailRd)
        mailABFlagN_reg <= 1'b1;
      if (bMailWr & mailBAFlagN_reg)
        mailBAFlagN_reg <= 1'b0;
      else if (aMailRd)
        mailBAFlagN_reg <= 1'b1;
    end
  end

  assign a_to_b_mail_flag_n = mailABFlagN_reg;
  assign b_to_a_mail_flag_n = mailBAFlagN_reg;

  // ----------------------------------------------------------------
  // port B width selection and forward reads
  // ----------------------------------------------------------------
  logic [1:0] sizeQ_reg; // stored size select
  logic endianQ_reg; // stored endian select, low big
  bfmpc_width_t bw; // width applied at this edge
  bfmpc_width_t lastBw_reg; // width of the word in progress
  logic lastBig_reg; // endian of the word in progress
  logic [DATA_W-1:0] aux_reg; // remaining portions, pre-shifted
  logic [DATA_W-1:0] fwdOut_reg; // forward output register
  logic bRdOk, bContinue; // accepted read, served from auxiliary

  assign bw = bfmpc_width_t'(sizeQ_reg);
  assign bRdOk = bFifoRd & nextB[F_EMPTY];
  assign bContinue = (auxLeft_reg != 2'h0) & (bw == lastBw_reg) &
                     (~endianQ_reg == lastBig_reg);
  assign fwdRdFetch = bRdOk & ~bContinue & (fwdCnt_reg != '0);

  // sizes stored on each edge; a mailbox access keeps the old size
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sizeQ_reg <= BW_LONG;
      endianQ_reg <= 1'b1;
    end
    else if (edgeB && !bMail)
    begin
      sizeQ_reg <= ctlB.size;
      endianQ_reg <= ctlB.endianN;
    end
  end

  // long words go out whole; narrow ones shift portion by portion
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aux_reg <= '0;
      fwdOut_reg <= '0;
      auxLeft_reg <= '0;
      lastBw_reg <= BW_LONG;
      lastBig_reg <= 1'b0;
    end
    else if (bRdOk && bContinue)
    begin
      fwdOut_reg <= aux_reg;
      aux_reg <= nextPortion(aux_reg, lastBw_reg, lastBig_reg);
      auxLeft_reg <= auxLeft_reg - 2'h1;
    end
    else if (fwdRdFetch)
    begin
      fwdOut_reg <= fwdMem[fwdRdPtr_reg];
      aux_reg <= nextPortion(fwdMem[fwdRdPtr_reg], bw, ~endianQ_reg);
      lastBw_reg <= bw;
      lastBig_reg <= ~endianQ_reg;
      case (bw)
        BW_WORD: auxLeft_reg <= 2'h1;
        BW_BYTE: auxLeft_reg <= 2'h3;
        default: auxLeft_reg <= 2'h0;
      endcase
    end
    else if (bRdOk)
    begin
      // changed width with no word to fetch: the leftover is dropped
      auxLeft_reg <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // port A reverse output and data buses
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] revOut_reg; // reverse output register

  // reverse queue read into port A output register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      revOut_reg <= '0;
    else if (revRdOk)
      revOut_reg <= revMem[revRdPtr_reg];
  end

  // bus data chosen by the mailbox selects, mailbox data unsized
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      portADataOut <= '0;
      portBDataOut <= '0;
    end
    else
    begin
      portADataOut <= ctlA.mbSel ? mailBA_reg : revOut_reg;
      portBDataOut <= bMail ? mailAB_reg : fwdOut_reg;
    end
  end

  // drivers on while selected and reading
  assign portADataOe = ~ctlA.selectN & ~ctlA.dir;
  assign portBDataOe = ~ctlB.selectN & ~ctlB.dir;

endmodule

// file: verification/bfmpc_properties.sv
// Purpose: concurrent checks on the queue port control pins
// Assumes: port clocks are slow against ref_clk
// Notes: bound to the top module
`timescale 1ns/1ps
module bfmpc_properties
(
  // system
  input wire logic ref_clk,
  input wire logic reset_n,
  // port pins
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_dir,
  input wire logic port_a_enable,
  input wire logic port_a_mailbox_sel,
  input wire logic portADataOe,
  input wire logic port_b_select_n,
  input wire logic port_b_dir,
  input wire logic port_b_enable,
  input wire logic port_b_width_sel0,
  input wire logic port_b_width_sel1,
  // flags
  input wire logic port_a_almost_full_n,
  input wire logic port_a_full_n,
  input wire logic port_b_empty_n,
  input wire logic port_b_almost_empty_n,
  input wire logic a_to_b_mail_flag_n,
  input wire logic b_to_a_mail_flag_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // decoded port operations
  wire aOp = !port_a_select_n && port_a_enable && port_a_mailbox_sel;
  wire bOp = !port_b_select_n && port_b_enable && port_b_width_sel0 && port_b_width_sel1;
  mail_reset_a:
    assert property ($rose(reset_n) |-> a_to_b_mail_flag_n && b_to_a_mail_flag_n)
    else $error("mail flags low after reset");
  ab_fall_a:
    assert property ($fell(a_to_b_mail_flag_n) |-> $past(aOp && port_a_dir, 2))
    else $error("a to b flag fell without write");
  ab_rise_a:
    assert property ($rose(a_to_b_mail_flag_n) |-> $past(bOp && !port_b_dir, 2))
    else $error("a to b flag rose without read");
  ba_fall_a:
    assert property ($fell(b_to_a_mail_flag_n) |-> $past(bOp && port_b_dir, 2))
    else $error("b to a flag fell without write");
  ba_rise_a:
    assert property ($rose(b_to_a_mail_flag_n) |-> $past(aOp && !port_a_dir, 2))
    else $error("b to a flag rose without read");
  full_order_a:
    assert property (!port_a_full_n |-> !port_a_almost_full_n)
    else $error("full without almost full");
  empty_order_a:
    assert property (!port_b_empty_n |-> !port_b_almost_empty_n)
    else $error("empty without almost empty");
  flag_sync_a:
    assert property ($changed(port_a_full_n) |-> $past(port_a_clock, 2))
    else $error("full flag moved off its clock");
  // main scenarios
  cover property (aOp && port_a_dir);
  cover property (bOp && !port_b_dir);
  cover property (!port_a_full_n);
endmodule
bind bfmpc_top bfmpc_properties u_bfmpc_properties (.ref_clk, .reset_n, .port_a_clock,
  .port_a_select_n, .port_a_dir, .port_a_enable, .port_a_mailbox_sel, .portADataOe,
  .port_b_select_n, .port_b_dir, .port_b_enable, .port_b_width_sel0, .port_b_width_sel1,
  .port_a_almost_full_n, .port_a_full_n, .port_b_empty_n, .port_b_almost_empty_n,
  .a_to_b_mail_flag_n, .b_to_a_mail_flag_n);

// file: verification/bfmpc_port_agent.sv
// Purpose: processor on one port, free-running port clock
// Assumes: one operation per port clock rise
// Notes: released write lines show the inverse value
`timescale 1ns/1ps
module bfmpc_port_agent
  import bfmpc_pkg::*;
#(
  parameter int HALF_NS = 120,
  parameter int PHASE_NS = 7
)
(
  // clocks
  input wire logic ref_clk,
  output logic pclk,
  // controls
  output logic selN,
  output logic dir,
  output logic en,
  output logic [1:0] sel,
  output logic endian,
  // data
  output logic [DATA_W-1:0] wData,
  input wire logic [DATA_W-1:0] rData
);
  // idle levels, then the free clock
  initial
  begin
    {selN, dir, en, sel, endian, wData} = {1'b1, 4'h0, 1'b0, 36'h0};
    pclk = 1'b0;
    #(PHASE_NS);
    forever #(HALF_NS) pclk = ~pclk;
  end
  // one operation, held across a whole port clock rise
  task automatic op(input logic d, input logic e, input logic [1:0] s,
                    input logic [DATA_W-1:0] w, output logic [DATA_W-1:0] r);
    @(negedge pclk);
    @(posedge ref_clk);
    #1;
    {selN, dir, en, sel, wData} = {1'b0, d, e, s, w};
    @(posedge pclk);
    @(negedge pclk);
    @(posedge ref_clk);
    #1;
    r = rData;
    {selN, en, wData} = {1'b1, 1'b0, ~wData};
  endtask
  // endian select, held until changed again
  task automatic set_endian(input logic v);
    endian = v;
  endtask
endmodule

// file: verification/bfmpc_top_tb.sv
// Purpose: self-checking bench for the queue port control
// Assumes: offset preset 4, then 16 after a mid-run reset
// Notes: one task per scenario
`timescale 1ns/1ps
module bfmpc_top_tb;
  import bfmpc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] offsetSel = 2'h0;
  int failCount = 0;
  int samplesChecked = 0;
  logic [DATA_W-1:0] rd, aOut, bOut, aWd, bWd;
  logic [1:0] aSel, bSel;
  logic aClk, aSelN, aDir, aEn, aOe, bClk, bSelN, bDir, bEn, bEnd, bOe;
  logic aEmN, aAeN, aAfN, aFuN, bEmN, bAeN, bAfN, bFuN, abN, baN;
  always #10 ref_clk = ~ref_clk;
  bfmpc_top u_bfmpc_top (.ref_clk(ref_clk), .reset_n(reset_n), .port_a_clock(aClk),
    .port_a_select_n(aSelN), .port_a_dir(aDir), .port_a_enable(aEn),
    .port_a_mailbox_sel(aSel[0]), .portADataIn(aWd), .portADataOut(aOut), .portADataOe(aOe),
    .port_b_clock(bClk), .port_b_select_n(bSelN), .port_b_dir(bDir), .port_b_enable(bEn),
    .port_b_width_sel0(bSel[0]), .port_b_width_sel1(bSel[1]), .port_b_endian_sel(bEnd),
    .portBDataIn(bWd), .portBDataOut(bOut), .portBDataOe(bOe), .offsetSel(offsetSel),
    .port_a_empty_n(aEmN), .port_a_almost_empty_n(aAeN), .port_a_almost_full_n(aAfN),
    .port_a_full_n(aFuN), .port_b_empty_n(bEmN), .port_b_almost_empty_n(bAeN),
    .port_b_almost_full_n(bAfN), .port_b_full_n(bFuN), .a_to_b_mail_flag_n(abN),
    .b_to_a_mail_flag_n(baN));
  bfmpc_port_agent #(.HALF_NS(120), .PHASE_NS(7)) u_agent_a (.ref_clk(ref_clk),
    .pclk(aClk), .selN(aSelN), .dir(aDir), .en(aEn), .sel(aSel), .endian(),
    .wData(aWd), .rData(aOut));
  bfmpc_port_agent #(.HALF_NS(130), .PHASE_NS(13)) u_agent_b (.ref_clk(ref_clk),
    .pclk(bClk), .selN(bSelN), .dir(bDir), .en(bEn), .sel(bSel), .endian(bEnd),
    .wData(bWd), .rData(bOut));
  // distinct bytes per word
  function automatic logic [DATA_W-1:0] word(input int i);
    return {9'(i + 1), 9'(i + 2), 9'(i + 3), 9'(i + 4)};
  endfunction
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // mailbox a to b: second write refused while unread
  task automatic test_mail_ab();
    u_agent_a.op(1'b1, 1'b1, 2'h1, 36'h1_2345_6789, rd);
    check("ab flag", abN, 1'b0);
    u_agent_a.op(1'b1, 1'b1, 2'h1, 36'h0_dead_beef, rd);
    u_agent_b.op(1'b0, 1'b1, 2'h3, 36'h0, rd);
    check("ab mail", rd, 36'h1_2345_6789);
    check("ab flag", abN, 1'b1);
  endtask
  // mailbox b to a, read twice
  task automatic test_mail_ba();
    u_agent_b.op(1'b1, 1'b1, 2'h3, 36'h8_7654_3210, rd);
    check("ba flag", baN, 1'b0);
    repeat (2) u_agent_a.op(1'b0, 1'b1, 2'h1, 36'h0, rd);
    check("ba mail", rd, 36'h8_7654_3210);
    check("ba flag", baN, 1'b1);
  endtask
  // forward queue sizing, endian, width change
  task automatic test_fwd();
    for (int i = 0; i < 5; i++) u_agent_a.op(1'b1, 1'b1, 2'h0, word(i), rd);
    repeat (2) u_agent_b.op(1'b0, 1'b0, 2'h0, 36'h0, rd);
    check("b flags", {bEmN, bAeN}, 2'h3);
    u_agent_b.op(1'b0, 1'b1, 2'h0, 36'h0, rd);
    check("long", rd, word(0));
    u_agent_b.set_endian(1'b1);
    u_agent_b.op(1'b0, 1'b0, 2'h2, 36'h0, rd);
    for (int k = 0; k < 4; k++)
    begin
      u_agent_b.op(1'b0, 1'b1, 2'h2, 36'h0, rd);
      check("byte", 36'(rd[8:0]), 36'(9'(word(1) >> (k * 9))));
    end
    u_agent_b.set_endian(1'b0);
    u_agent_b.op(1'b0, 1'b0, 2'h1, 36'h0, rd);
    u_agent_b.op(1'b0, 1'b1, 2'h1, 36'h0, rd);
    check("half", 36'(rd[35:18]), 36'(18'(word(2) >> 18)));
    u_agent_b.op(1'b0, 1'b0, 2'h0, 36'h0, rd);
    u_agent_b.op(1'b0, 1'b1, 2'h0, 36'h0, rd);
    check("fresh", rd, word(3));
  endtask
  // fill to full, refused write, drain to empty
  task automatic test_full();
    for (int i = 5; i < 68; i++) u_agent_a.op(1'b1, 1'b1, 2'h0, word(i), rd);
    // the full level reaches the pin one port A edge after the last write
    u_agent_a.op(1'b1, 1'b1, 2'h0, word(99), rd);
    check("a full", {aAfN, aFuN}, 2'h0);
    for (int i = 4; i < 68; i++)
    begin
      u_agent_b.op(1'b0, 1'b1, 2'h0, 36'h0, rd);
      check("drain", rd, word(i));
      if (i == 8)
      begin
        repeat (2) u_agent_a.op(1'b0, 1'b0, 2'h0, 36'h0, rd);
        check("a almost full", aAfN, 1'b1);
      end
    end
    u_agent_b.op(1'b0, 1'b1, 2'h0, 36'h0, rd);
    check("b empty", bEmN, 1'b0);
    check("empty read", rd, word(67));
  endtask
  // reverse queue through to port A
  task automatic test_rev();
    u_agent_b.op(1'b1, 1'b1, 2'h0, word(200), rd);
    repeat (2) u_agent_a.op(1'b0, 1'b0, 2'h0, 36'h0, rd);
    u_agent_a.op(1'b0, 1'b1, 2'h0, 36'h0, rd);
    check("rev word", rd, word(200));
    u_agent_a.op(1'b0, 1'b0, 2'h0, 36'h0, rd);
    check("a empty", aEmN, 1'b0);
  endtask
  // every flag and both drivers at their reset levels
  task automatic check_reset();
    #1;
    check("reset mail flags, drivers", {abN, baN, aOe, bOe}, 4'hc);
    check("reset queue flags", {aEmN, aAeN, aAfN, aFuN, bEmN, bAeN, bAfN, bFuN}, 8'h33);
  endtask
  // mid-run reset with the largest offset preset
  task automatic test_strap();
    reset_n = 1'b0;
    offsetSel = 2'h3;
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    check_reset();
    for (int i = 0; i < 17; i++)
    begin
      if (i == 16)
        check("ae at offset", bAeN, 1'b0);
      u_agent_a.op(1'b1, 1'b1, 2'h0, word(i), rd);
    end
    repeat (2) u_agent_b.op(1'b0, 1'b0, 2'h0, 36'h0, rd);
    check("ae past offset", bAeN, 1'b1);
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    check_reset();
    test_mail_ab();
    test_mail_ba();
    test_fwd();
    test_full();
    test_rev();
    test_strap();
    report_and_stop();
  end
  initial
  begin
    #400us;
    failCount++;
    report_and_stop();
  end
endmodule
